/* hw/gci_reset_sync.sv */
// Reset release synchroniser with parameterised depth
`timescale 1ns/1ps
`default_nettype none
module gci_reset_sync #(
   parameter int STAGES = 2
) (
   input wire logic clk,
   input wire logic arst_n,
   output logic rst_n
);
   logic [STAGES-1:0] sync_q;
   // Assert at once, release after STAGES edges
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_q <= '0;
      end else begin
         sync_q <= {sync_q[STAGES-2:0], 1'b1};
      end
   end
   assign rst_n = sync_q[STAGES-1];
endmodule
`default_nettype wire

/* hw/gci_top.sv */
// Global interrupt outputs and control-port reset for the bridge
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gci_top
   import gci_pkg::*;
#(
   parameter int W = gci_pkg::GCI_REG_W,
   parameter bit ROOT_PORT_DECODE = 1'b1
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [gci_pkg::GCI_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [W-1:0] ev_pend1,
   input wire logic [W-1:0] ev_pend2,
   input wire logic [W-1:0] ev_rplo,
   input wire logic [W-1:0] ev_rphi,
   output logic irq_combined,
   output logic rp_msg_low_vector_irq,
   output logic rp_msg_high_vector_irq,
   output logic ctl_resetn
);
   import gci_pkg::*;

   typedef struct packed {
      logic [W-1:0] pend1;
      logic [W-1:0] mask1;
      logic [W-1:0] pend2;
      logic [W-1:0] mask2;
      logic [W-1:0] rplo_pend;
      logic [W-1:0] rplo_mask;
      logic [W-1:0] rphi_pend;
      logic [W-1:0] rphi_mask;
      logic [31:0] rdata;
      logic irq;
      logic lo_irq;
      logic hi_irq;
   } gci_state_type;

   gci_state_type s_q, s_d;
   logic rst_n;

   // Reset input released through two flip-flops; the card reset feeds resetn
   // The same copy is the control-port reset, so it lifts two edges after resetn
   gci_reset_sync #(.STAGES(GCI_CTL_RST_CYCLES)) u_rst (
      .clk(core_clk),
      .arst_n(resetn),
      .rst_n(rst_n)
   );

   // Write-one-to-clear pending, set wins over clear
   function automatic logic [W-1:0] pend_next(input logic [W-1:0] cur, input logic [W-1:0] ev,
                                              input logic clr, input logic [31:0] wd);
      logic [W-1:0] v;
      v = cur;
      if (clr) begin
         v = v & ~wd[W-1:0];
      end
      pend_next = v | ev;
   endfunction

   // Next state: register file, read data, irq levels
   always_comb begin
      s_d = s_q;
      s_d.pend1 = pend_next(s_q.pend1, ev_pend1, reg_wr && reg_addr == GCI_OFF_PEND1, reg_wdata);
      s_d.pend2 = pend_next(s_q.pend2, ev_pend2, reg_wr && reg_addr == GCI_OFF_PEND2, reg_wdata);
      s_d.rplo_pend = pend_next(s_q.rplo_pend, ev_rplo, reg_wr && reg_addr == GCI_OFF_RPLO_PEND,
                                reg_wdata);
      s_d.rphi_pend = pend_next(s_q.rphi_pend, ev_rphi, reg_wr && reg_addr == GCI_OFF_RPHI_PEND,
                                reg_wdata);
      if (reg_wr) begin
         unique case (reg_addr)
            GCI_OFF_MASK1: s_d.mask1 = reg_wdata[W-1:0];
            GCI_OFF_MASK2: s_d.mask2 = reg_wdata[W-1:0];
            GCI_OFF_RPLO_MASK: s_d.rplo_mask = reg_wdata[W-1:0];
            GCI_OFF_RPHI_MASK: s_d.rphi_mask = reg_wdata[W-1:0];
            default: ;
         endcase
      end
      // Read data valid only in the cycle after the strobe
      s_d.rdata = 32'h00000000;
      if (reg_rd) begin
         unique case (reg_addr)
            GCI_OFF_PEND1: s_d.rdata = 32'(s_q.pend1);
            GCI_OFF_MASK1: s_d.rdata = 32'(s_q.mask1);
            GCI_OFF_PEND2: s_d.rdata = 32'(s_q.pend2);
            GCI_OFF_MASK2: s_d.rdata = 32'(s_q.mask2);
            GCI_OFF_RPLO_PEND: s_d.rdata = 32'(s_q.rplo_pend);
            GCI_OFF_RPLO_MASK: s_d.rdata = 32'(s_q.rplo_mask);
            GCI_OFF_RPHI_PEND: s_d.rdata = 32'(s_q.rphi_pend);
            GCI_OFF_RPHI_MASK: s_d.rdata = 32'(s_q.rphi_mask);
            GCI_OFF_STATUS: s_d.rdata = {28'h0000000, rst_n, s_q.hi_irq, s_q.lo_irq, s_q.irq};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      // Levels registered for clean outputs; one cycle behind the pending bits
      s_d.irq = |(s_q.pend1 & ~s_q.mask1) || |(s_q.pend2 & ~s_q.mask2);
      s_d.lo_irq = ROOT_PORT_DECODE && |(s_q.rplo_pend & ~s_q.rplo_mask);
      s_d.hi_irq = ROOT_PORT_DECODE && |(s_q.rphi_pend & ~s_q.rphi_mask);
   end

   // Reset clears all state except the masks, which load all masked, so every irq is low during it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{pend1: GCI_PEND_RST[W-1:0], mask1: GCI_MASK_RST[W-1:0],
                  pend2: GCI_PEND_RST[W-1:0], mask2: GCI_MASK_RST[W-1:0],
                  rplo_pend: GCI_PEND_RST[W-1:0], rplo_mask: GCI_MASK_RST[W-1:0],
                  rphi_pend: GCI_PEND_RST[W-1:0], rphi_mask: GCI_MASK_RST[W-1:0],
                  rdata: 32'h00000000, irq: 1'b0, lo_irq: 1'b0, hi_irq: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs from flip-flops; clock may stop in reset, state holds then
   assign reg_rdata = s_q.rdata;
   assign irq_combined = s_q.irq;
   assign rp_msg_low_vector_irq = s_q.lo_irq;
   assign rp_msg_high_vector_irq = s_q.hi_irq;
   assign ctl_resetn = rst_n; // Control clock is core_clk here

   // Pending unmasked bit shows on combined irq after one edge
   property p_irq_follow;
      @(posedge core_clk) disable iff (!rst_n)
      |(s_q.pend1 & ~s_q.mask1) |=> irq_combined;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("combined irq missing");

   property p_irq_pair2;
      @(posedge core_clk) disable iff (!rst_n)
      |(s_q.pend2 & ~s_q.mask2) |=> irq_combined;
   endproperty
   a_irq_pair2: assert property (p_irq_pair2) else $error("combined irq missing pair two");

   property p_irq_quiet;
      @(posedge core_clk) disable iff (!rst_n)
      !(|(s_q.pend1 & ~s_q.mask1) || |(s_q.pend2 & ~s_q.mask2)) |=> !irq_combined;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("combined irq spurious");

   property p_lo_irq;
      @(posedge core_clk) disable iff (!rst_n)
      ##1 (rp_msg_low_vector_irq == (ROOT_PORT_DECODE && $past(|(s_q.rplo_pend & ~s_q.rplo_mask))));
   endproperty
   a_lo_irq: assert property (p_lo_irq) else $error("low vector irq wrong");

   property p_lo_absent;
      @(posedge core_clk) !ROOT_PORT_DECODE |-> !rp_msg_low_vector_irq;
   endproperty
   a_lo_absent: assert property (p_lo_absent) else $error("low vector irq outside root port");

   property p_hi_irq;
      @(posedge core_clk) disable iff (!rst_n)
      ##1 (rp_msg_high_vector_irq == (ROOT_PORT_DECODE && $past(|(s_q.rphi_pend & ~s_q.rphi_mask))));
   endproperty
   a_hi_irq: assert property (p_hi_irq) else $error("high vector irq wrong");

   // Control-port reset: low at the first two sampled edges after release, high at the third
   sequence s_rst_rel;
      $rose(resetn);
   endsequence
   sequence s_ctl_lift;
      !ctl_resetn ##1 !ctl_resetn ##1 ctl_resetn;
   endsequence
   property p_ctl_rst;
      @(posedge core_clk) disable iff (!resetn) s_rst_rel |-> s_ctl_lift;
   endproperty
   a_ctl_rst: assert property (p_ctl_rst) else $error("control reset release timing");

   property p_ctl_hold;
      @(posedge core_clk) !resetn |-> !ctl_resetn;
   endproperty
   a_ctl_hold: assert property (p_ctl_hold) else $error("control reset lifted early");

   property p_rst_quiet;
      @(posedge core_clk) !rst_n |-> !irq_combined && !rp_msg_low_vector_irq && !rp_msg_high_vector_irq;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("irq during reset");

   // Every event bit lands in its pending register, even beside a clearing write
   property p_pend1_set;
      @(posedge core_clk) disable iff (!rst_n)
      |ev_pend1 |=> (s_q.pend1 & $past(ev_pend1)) == $past(ev_pend1);
   endproperty
   a_pend1_set: assert property (p_pend1_set) else $error("pair one event lost");

   property p_pend2_set;
      @(posedge core_clk) disable iff (!rst_n)
      |ev_pend2 |=> (s_q.pend2 & $past(ev_pend2)) == $past(ev_pend2);
   endproperty
   a_pend2_set: assert property (p_pend2_set) else $error("pair two event lost");

   property p_rplo_set;
      @(posedge core_clk) disable iff (!rst_n)
      |ev_rplo |=> (s_q.rplo_pend & $past(ev_rplo)) == $past(ev_rplo);
   endproperty
   a_rplo_set: assert property (p_rplo_set) else $error("low vector event lost");

   property p_rphi_set;
      @(posedge core_clk) disable iff (!rst_n)
      |ev_rphi |=> (s_q.rphi_pend & $past(ev_rphi)) == $past(ev_rphi);
   endproperty
   a_rphi_set: assert property (p_rphi_set) else $error("high vector event lost");

   property p_hi_absent;
      @(posedge core_clk) !ROOT_PORT_DECODE |-> !rp_msg_high_vector_irq;
   endproperty
   a_hi_absent: assert property (p_hi_absent) else $error("high vector irq outside root port");
endmodule
`default_nettype wire

/* shared/gci_pkg.sv */
// Package for the global clock and interrupt output block
package gci_pkg;
   // Width of each pending and mask register
   localparam int GCI_REG_W = 32;
   // Register offsets (own map, plain port bus)
   localparam logic [3:0] GCI_OFF_PEND1 = 4'h0;
   localparam logic [3:0] GCI_OFF_MASK1 = 4'h1;
   localparam logic [3:0] GCI_OFF_PEND2 = 4'h2;
   localparam logic [3:0] GCI_OFF_MASK2 = 4'h3;
   localparam logic [3:0] GCI_OFF_RPLO_PEND = 4'h4;
   localparam logic [3:0] GCI_OFF_RPLO_MASK = 4'h5;
   localparam logic [3:0] GCI_OFF_RPHI_PEND = 4'h6;
   localparam logic [3:0] GCI_OFF_RPHI_MASK = 4'h7;
   localparam logic [3:0] GCI_OFF_STATUS = 4'h8;
   localparam int GCI_ADDR_W = 4;
   // Reset values: masks reset to all masked
   localparam logic [31:0] GCI_PEND_RST = 32'h00000000;
   localparam logic [31:0] GCI_MASK_RST = 32'hFFFFFFFF;
   // Control-port reset release delay in control-port clock cycles
   localparam int GCI_CTL_RST_CYCLES = 2;
endpackage

/* verification/gci_irq_sink.sv */
// Model of the interrupt controller in user logic beside the bridge
`timescale 1ns/1ps
`default_nettype none
module gci_irq_sink (
   input wire logic core_clk,
   input wire logic [2:0] irq_lines,
   output logic [15:0] irq_seen
);
   logic prev_q;
   // Counts rising edges of the OR of the level irqs, on the bridge clock only, as it may stop in reset
   initial irq_seen = 16'h0000;
   initial prev_q = 1'b0;
   always @(posedge core_clk) begin
      prev_q <= |irq_lines;
      if (|irq_lines && !prev_q) begin
         irq_seen <= irq_seen + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* verification/global_clock_and_irq_outputs_bench.sv */
// Self-checking bench for the global interrupt outputs
`timescale 1ns/1ps
`default_nettype none
module global_clock_and_irq_outputs_bench;
   import gci_pkg::*;
   logic core_clk, resetn, reg_wr, reg_rd, irq_c, lo, hi, ctl_resetn, x;
   logic irq_c2, lo2, hi2, clk_run;
   int ev_sel, exp_rises;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, e, m;
   logic [31:0] ev [4];
   logic [2:0] xv;
   logic [15:0] seen;
   int fails, cmp_count;
   gci_top dut_u (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_pend1(ev[0]), .ev_pend2(ev[1]), .ev_rplo(ev[2]), .ev_rphi(ev[3]),
      .irq_combined(irq_c), .rp_msg_low_vector_irq(lo), .rp_msg_high_vector_irq(hi), .ctl_resetn(ctl_resetn));
   // Copy without root-port decode: both vector outputs must stay absent
   gci_top #(.ROOT_PORT_DECODE(1'b0)) dut_ep_u (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .ev_pend1(ev[0]), .ev_pend2(ev[1]),
      .ev_rplo(ev[2]), .ev_rphi(ev[3]), .irq_combined(irq_c2), .rp_msg_low_vector_irq(lo2),
      .rp_msg_high_vector_irq(hi2), .ctl_resetn());
   gci_irq_sink sink_u (.core_clk(core_clk), .irq_lines({hi, lo, irq_c}), .irq_seen(seen));
   // Bridge clock, 200 MHz, also the control clock; it may be held still during reset
   initial begin
      clk_run = 1'b1;
      core_clk = 1'b0;
      forever #2.5 core_clk = clk_run ? ~core_clk : 1'b0;
   end
   task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
      cmp_count++;
      if (seen_v !== exp_v) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just after that edge
   task automatic rd(input logic [3:0] a, input logic [31:0] exp_v);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp_v);
      @(posedge core_clk);
      #1 chk(reg_rdata, 32'h00000000);
   endtask
   // Pulses one event word into source k, then waits until the level irq has settled
   task automatic pulse(input int k, input logic [31:0] d);
      ev_sel = k;
      @(posedge core_clk);
      ev[ev_sel] <= d;
      @(posedge core_clk);
      ev[ev_sel] <= 32'h00000000;
      cyc(1);
      #1;
   endtask
   function automatic logic irq_exp(input logic [31:0] p, input logic [31:0] msk);
      return |(p & ~msk);
   endfunction
   task automatic finish_test;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      cyc(4000);
      fails++;
      finish_test;
   end
   // Main sequence
   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h00000000;
      foreach (ev[j]) ev[j] = 32'h00000000;
      ev_sel = 0;
      exp_rises = 0;
      fails = 0;
      cmp_count = 0;
      void'($urandom(32'h7DDC));
      cyc(11);
      #1 chk({hi, lo, irq_c, ctl_resetn}, 32'h0);
      cyc(1);
      resetn <= 1'b1;
      cyc(1);
      #1 chk(ctl_resetn, 32'h0);
      cyc(1);
      #1 chk(ctl_resetn, 32'h1);
      rd(GCI_OFF_MASK1, 32'hFFFFFFFF);
      rd(4'hF, 32'h00000000);
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 6; i++) begin
            e = (i == 0) ? 32'h00000001 : $urandom;
            m = (i == 0) ? 32'hFFFFFFFE : (i == 1) ? (e | 32'h80000000) : $urandom;
            x = irq_exp(e, m);
            xv = {x && k == 3, x && k == 2, x && k < 2};
            exp_rises += int'(x);
            wr(4'(2 * k + 1), m);
            pulse(k, e);
            chk({hi, lo, irq_c}, xv);
            chk({hi2, lo2, irq_c2}, {2'b00, xv[0]});
            rd(4'(2 * k), e);
            rd(GCI_OFF_STATUS, {28'h0, 1'b1, xv});
            wr(4'(2 * k), 32'hFFFFFFFF);
            cyc(2);
            #1 chk({hi2, lo2, irq_c2, hi, lo, irq_c}, 32'h0);
         end
      end
      // Reset in mid-run with an irq standing drops every output at once, even with the clock held still
      wr(GCI_OFF_MASK1, 32'h00000000);
      pulse(0, 32'h00000004);
      exp_rises++;
      chk(irq_c, 32'h1);
      @(posedge core_clk);
      resetn <= 1'b0;
      #2 chk({hi, lo, irq_c, ctl_resetn}, 32'h0);
      clk_run = 1'b0;
      #20 chk({hi, lo, irq_c, ctl_resetn, irq_c2}, 32'h0);
      clk_run = 1'b1;
      cyc(2);
      resetn <= 1'b1;
      cyc(4);
      rd(GCI_OFF_PEND1, 32'h00000000);
      rd(GCI_OFF_MASK1, 32'hFFFFFFFF);
      chk(32'(seen), 32'(exp_rises));
      finish_test;
   end
endmodule
`default_nettype wire
